// >>> link_param_pkg.sv
// Register offsets, field positions, reset values and fixed parameters.
package link_param_pkg;
    localparam logic [7:0] scramble_lane_config_addr = 8'h6e;
    localparam logic [7:0] octets_per_frame_addr = 8'h6f;
    localparam logic [7:0] frames_per_multiframe_addr = 8'h70;
    localparam logic [7:0] converter_count_addr = 8'h71;
    localparam logic [7:0] control_bits_resolution_addr = 8'h72;
    localparam logic [7:0] subclass_sample_bits_addr = 8'h73;
    localparam logic [7:0] samples_per_frame_addr = 8'h74;
    localparam logic [7:0] density_control_words_addr = 8'h75;
    localparam logic [7:0] spare_scratch_a_addr = 8'h76;
    localparam logic [7:0] spare_scratch_b_addr = 8'h77;
    localparam logic [7:0] link_config_checksum_addr = 8'h79;
    localparam logic [7:0] output_driver_control_addr = 8'h80;
    localparam logic [7:0] multiframe_phase_offset_addr = 8'h8b;
    localparam logic [7:0] output_preemphasis_addr = 8'ha8;

    localparam int scramble_bit = 7;
    localparam int driver_power_down_bit = 1;
    localparam int sample_bit5 = 5;

    localparam logic [7:0] scramble_lane_reset = 8'h80;
    localparam logic [7:0] frames_per_multiframe_reset = 8'h1f;
    localparam logic [7:0] converter_count_reset = 8'h00;
    localparam logic [1:0] control_bits_reset = 2'h0;
    localparam logic [1:0] subclass_reset = 2'h1;
    localparam logic [7:0] spare_reset = 8'h00;
    localparam logic [7:0] driver_control_reset = 8'h00;
    localparam logic [4:0] phase_offset_reset = 5'h00;
    localparam logic [7:0] preemphasis_off = 8'h04;
    localparam logic [7:0] preemphasis_on = 8'h14;

    localparam logic [3:0] resolution_code = 4'hd;
    localparam logic [3:0] sample_bits_code = 4'hf;
    localparam logic [4:0] samples_per_frame_code = 5'h00;
    localparam logic [4:0] control_words_code = 5'h00;
    localparam logic [7:0] octets_per_frame_value = 8'h02;

    typedef enum logic [1:0] {
        control_none = 2'b00,
        control_overrange = 2'b01,
        control_over_under = 2'b10
    } control_bits_e;
endpackage

// >>> phase_counter.sv
// Local multiframe phase counter with reference-driven reload.
`timescale 1ns/1ns
module phase_counter #(
    parameter int WIDTH = 5
) (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic frame_tick_in,
    input wire logic reload_in,
    input wire logic [WIDTH-1:0] reload_value_in,
    input wire logic [WIDTH-1:0] last_in,
    output logic [WIDTH-1:0] phase_out,
    output logic wrap_out
);
    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] next_count;
    wire at_last = (count == last_in);

    assign next_count = at_last ? '0 : count + WIDTH'(1);

    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            count <= '0;
            wrap_out <= 1'b0;
        end
        else if (reload_in)
        begin
            count <= reload_value_in;
            wrap_out <= 1'b0;
        end
        else
        begin
            if (frame_tick_in)
            begin
                count <= next_count;
            end
            wrap_out <= frame_tick_in & at_last;
        end
    end

    assign phase_out = count;
endmodule

// >>> serial_link_param_regs.sv
// Link parameter register bank with derived readbacks and phase counter.
//
// Behaviour
// - Bit 7 enables payload scrambling.
// - Lane field zero means one lane.
// - Octets per frame reads twice M over L.
// - Converter count zero selects primary input only.
// - Control-bits field selects none, overrange, over/under.
// - Resolution field reads 13, read-only.
// - Subclass field selects subclass 0 or 1.
// - Total sample bits field reads 15.
// - Samples per frame reads 0; bit 5 writable, set at reset.
// - High-density flag always reads zero.
// - Control words per frame reads zero.
// - Two spare registers are plain storage.
// - Checksum is modulo-256 sum of parameters.
// - Driver power-down bit disables output drivers.
// - Reference loads phase counter with offset.
// - Preemphasis on at 0x14, off at 0x04.
// - Reference ignored unless its enable is set.
`timescale 1ns/1ns
module serial_link_param_regs #(
    parameter int PHASE_WIDTH = 5
) (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    output logic [7:0] reg_rdata_out,
    output logic reg_hit_out,
    input wire logic sysref_pin_in,
    input wire logic sysref_enable_in,
    input wire logic frame_tick_in,
    output logic scramble_enable_out,
    output logic [4:0] lane_count_out,
    output logic [7:0] frames_per_multiframe_out,
    output logic [7:0] octets_per_frame_out,
    output logic primary_input_only_out,
    output logic [1:0] control_bits_out,
    output logic overrange_bit_enable_out,
    output logic over_under_bits_enable_out,
    output logic subclass1_out,
    output logic drivers_enable_out,
    output logic preemphasis_enable_out,
    output logic [PHASE_WIDTH-1:0] multiframe_phase_out,
    output logic multiframe_wrap_out,
    output logic [7:0] checksum_out
);
    logic [7:0] scramble_lane;
    logic [7:0] frames_per_mf;
    logic [7:0] converter_count;
    logic [1:0] control_bits;
    logic [1:0] subclass;
    logic sample_reserved_bit;
    logic [7:0] spare_a;
    logic [7:0] spare_b;
    logic [7:0] driver_control;
    logic [4:0] phase_offset;
    logic [7:0] preemphasis;
    logic [7:0] checksum;
    logic [7:0] next_checksum;
    logic [7:0] next_rdata;
    logic sysref_meta;
    logic sysref_sync;
    logic sysref_prev;

    wire wr_scramble = reg_write_in &
        (reg_addr_in == link_param_pkg::scramble_lane_config_addr);
    wire wr_frames = reg_write_in &
        (reg_addr_in == link_param_pkg::frames_per_multiframe_addr);
    wire wr_converter = reg_write_in &
        (reg_addr_in == link_param_pkg::converter_count_addr);
    wire wr_control = reg_write_in &
        (reg_addr_in == link_param_pkg::control_bits_resolution_addr);
    wire wr_subclass = reg_write_in &
        (reg_addr_in == link_param_pkg::subclass_sample_bits_addr);
    wire wr_samples = reg_write_in &
        (reg_addr_in == link_param_pkg::samples_per_frame_addr);
    wire wr_spare_a = reg_write_in &
        (reg_addr_in == link_param_pkg::spare_scratch_a_addr);
    wire wr_spare_b = reg_write_in &
        (reg_addr_in == link_param_pkg::spare_scratch_b_addr);
    wire wr_driver = reg_write_in &
        (reg_addr_in == link_param_pkg::output_driver_control_addr);
    wire wr_offset = reg_write_in &
        (reg_addr_in == link_param_pkg::multiframe_phase_offset_addr);
    wire wr_preemph = reg_write_in &
        (reg_addr_in == link_param_pkg::output_preemphasis_addr);

    // Control-bit writes hold only the three defined codes.
    wire control_code_ok = (reg_wdata_in[7:6] != 2'b11);

    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            scramble_lane <= link_param_pkg::scramble_lane_reset;
            frames_per_mf <= link_param_pkg::frames_per_multiframe_reset;
            converter_count <= link_param_pkg::converter_count_reset;
            control_bits <= link_param_pkg::control_bits_reset;
            subclass <= link_param_pkg::subclass_reset;
            sample_reserved_bit <= 1'b1;
            spare_a <= link_param_pkg::spare_reset;
            spare_b <= link_param_pkg::spare_reset;
            driver_control <= link_param_pkg::driver_control_reset;
            phase_offset <= link_param_pkg::phase_offset_reset;
            preemphasis <= link_param_pkg::preemphasis_off;
        end
        else
        begin
            if (wr_scramble)
            begin
                // Open bits 6:5 are not stored.
                scramble_lane <= {reg_wdata_in[7], 2'b00,
                    reg_wdata_in[4:0]};
            end
            if (wr_frames)
            begin
                frames_per_mf <= reg_wdata_in;
            end
            if (wr_converter)
            begin
                converter_count <= reg_wdata_in;
            end
            if (wr_control && control_code_ok)
            begin
                control_bits <= reg_wdata_in[7:6];
            end
            if (wr_subclass)
            begin
                subclass <= reg_wdata_in[6:5];
            end
            if (wr_samples)
            begin
                sample_reserved_bit <=
                    reg_wdata_in[link_param_pkg::sample_bit5];
            end
            if (wr_spare_a)
            begin
                spare_a <= reg_wdata_in;
            end
            if (wr_spare_b)
            begin
                spare_b <= reg_wdata_in;
            end
            if (wr_driver)
            begin
                driver_control <= {6'h00, reg_wdata_in[1], 1'b0};
            end
            if (wr_offset)
            begin
                phase_offset <= reg_wdata_in[4:0];
            end
            if (wr_preemph)
            begin
                preemphasis <= reg_wdata_in;
            end
        end
    end

    // Derived parameters: octets per frame is (M x 2) / L with biased codes.
    wire [8:0] conv_actual = {1'b0, converter_count} + 9'h001;
    wire [5:0] lane_actual = {1'b0, scramble_lane[4:0]} + 6'h01;
    wire [9:0] octet_num = {conv_actual, 1'b0};
    wire [9:0] octet_quot = octet_num / {4'h0, lane_actual};
    assign octets_per_frame_out = octet_quot[7:0];

    wire [7:0] reg_control = {control_bits, 2'b00,
        link_param_pkg::resolution_code};
    wire [7:0] reg_subclass = {1'b0, subclass, 1'b0,
        link_param_pkg::sample_bits_code};
    wire [7:0] reg_samples = {2'b00, sample_reserved_bit,
        link_param_pkg::samples_per_frame_code};
    wire [7:0] reg_density = {1'b0, 2'b00,
        link_param_pkg::control_words_code};

    // Sum of every link parameter field, wrapping at 256.
    always_comb
    begin
        next_checksum = 8'h00;
        next_checksum = next_checksum + {7'h00, scramble_lane[7]};
        next_checksum = next_checksum + {3'h0, scramble_lane[4:0]};
        next_checksum = next_checksum + octets_per_frame_out;
        next_checksum = next_checksum + frames_per_mf;
        next_checksum = next_checksum + converter_count;
        next_checksum = next_checksum + {6'h00, control_bits};
        next_checksum = next_checksum + {4'h0,
            link_param_pkg::resolution_code};
        next_checksum = next_checksum + {6'h00, subclass};
        next_checksum = next_checksum + {4'h0,
            link_param_pkg::sample_bits_code};
        next_checksum = next_checksum + {3'h0,
            link_param_pkg::samples_per_frame_code};
        next_checksum = next_checksum + {3'h0,
            link_param_pkg::control_words_code};
    end

    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            checksum <= 8'h00;
        end
        else
        begin
            checksum <= next_checksum;
        end
    end

    assign checksum_out = checksum;

    always_comb
    begin
        unique case (reg_addr_in)
            link_param_pkg::scramble_lane_config_addr:
                next_rdata = scramble_lane;
            link_param_pkg::octets_per_frame_addr:
                next_rdata = octets_per_frame_out;
            link_param_pkg::frames_per_multiframe_addr:
                next_rdata = frames_per_mf;
            link_param_pkg::converter_count_addr:
                next_rdata = converter_count;
            link_param_pkg::control_bits_resolution_addr:
                next_rdata = reg_control;
            link_param_pkg::subclass_sample_bits_addr:
                next_rdata = reg_subclass;
            link_param_pkg::samples_per_frame_addr:
                next_rdata = reg_samples;
            link_param_pkg::density_control_words_addr:
                next_rdata = reg_density;
            link_param_pkg::spare_scratch_a_addr:
                next_rdata = spare_a;
            link_param_pkg::spare_scratch_b_addr:
                next_rdata = spare_b;
            link_param_pkg::link_config_checksum_addr:
                next_rdata = checksum;
            link_param_pkg::output_driver_control_addr:
                next_rdata = driver_control;
            link_param_pkg::multiframe_phase_offset_addr:
                next_rdata = {3'h0, phase_offset};
            link_param_pkg::output_preemphasis_addr:
                next_rdata = preemphasis;
            default:
                next_rdata = 8'h00;
        endcase
    end

    wire addr_mapped = (reg_addr_in ==
        link_param_pkg::scramble_lane_config_addr) ||
        ((reg_addr_in >= link_param_pkg::octets_per_frame_addr) &&
        (reg_addr_in <= link_param_pkg::spare_scratch_b_addr)) ||
        (reg_addr_in == link_param_pkg::link_config_checksum_addr) ||
        (reg_addr_in == link_param_pkg::output_driver_control_addr) ||
        (reg_addr_in == link_param_pkg::multiframe_phase_offset_addr) ||
        (reg_addr_in == link_param_pkg::output_preemphasis_addr);

    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            reg_rdata_out <= 8'h00;
            reg_hit_out <= 1'b0;
        end
        else
        begin
            if (reg_read_in)
            begin
                reg_rdata_out <= next_rdata;
            end
            reg_hit_out <= (reg_read_in | reg_write_in) & addr_mapped;
        end
    end

    // The reference pin is asynchronous and is synchronised before use.
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            sysref_meta <= 1'b0;
            sysref_sync <= 1'b0;
            sysref_prev <= 1'b0;
        end
        else
        begin
            sysref_meta <= sysref_pin_in;
            sysref_sync <= sysref_meta;
            sysref_prev <= sysref_sync;
        end
    end

    wire sysref_edge = sysref_sync & ~sysref_prev & sysref_enable_in;

    phase_counter #(
        .WIDTH(PHASE_WIDTH)
    ) lmfc_counter (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .frame_tick_in(frame_tick_in),
        .reload_in(sysref_edge),
        .reload_value_in(phase_offset[PHASE_WIDTH-1:0]),
        .last_in(frames_per_mf[PHASE_WIDTH-1:0]),
        .phase_out(multiframe_phase_out),
        .wrap_out(multiframe_wrap_out)
    );

    assign scramble_enable_out = scramble_lane[link_param_pkg::scramble_bit];
    assign lane_count_out = scramble_lane[4:0];
    assign frames_per_multiframe_out = frames_per_mf;
    assign primary_input_only_out = (converter_count == 8'h00);
    assign control_bits_out = control_bits;
    assign overrange_bit_enable_out =
        (control_bits == link_param_pkg::control_overrange);
    assign over_under_bits_enable_out =
        (control_bits == link_param_pkg::control_over_under);
    assign subclass1_out = (subclass == 2'b01);
    assign drivers_enable_out =
        ~driver_control[link_param_pkg::driver_power_down_bit];
    assign preemphasis_enable_out =
        (preemphasis == link_param_pkg::preemphasis_on);
endmodule

// >>> link_param_props.sv
// Concurrent checks on the link parameter register bank ports.
`timescale 1ns/1ns
module link_param_props (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic reg_hit_out,
    input wire logic scramble_enable_out,
    input wire logic [4:0] lane_count_out,
    input wire logic [7:0] octets_per_frame_out,
    input wire logic primary_input_only_out,
    input wire logic [1:0] control_bits_out,
    input wire logic overrange_bit_enable_out,
    input wire logic over_under_bits_enable_out,
    input wire logic drivers_enable_out,
    input wire logic preemphasis_enable_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff reset_in;
    wire logic mapped = reg_addr_in inside {[8'h6e:8'h77], 8'h79, 8'h80,
        8'h8b, 8'ha8};
    sequence wr_at(logic [7:0] a);
        reg_write_in && reg_addr_in == a;
    endsequence
    sequence rd_any;
        reg_read_in && !reg_write_in;
    endsequence
    chk_mapped_read_hit: assert property ((rd_any ##0 mapped) |=> reg_hit_out)
        else $error("mapped read gave no hit");
    chk_unmapped_read_zero: assert property ((rd_any ##0 !mapped) |=>
        !reg_hit_out && reg_rdata_out == 8'h00)
        else $error("unmapped read not zero");
    chk_scramble_bit_write: assert property (wr_at(8'h6e) |=>
        scramble_enable_out == $past(reg_wdata_in[7]))
        else $error("scramble enable wrong");
    chk_driver_power_down: assert property (wr_at(8'h80) |=>
        drivers_enable_out != $past(reg_wdata_in[1]))
        else $error("driver enable wrong");
    chk_preemphasis_code: assert property (wr_at(8'ha8) |=>
        preemphasis_enable_out == ($past(reg_wdata_in) == 8'h14))
        else $error("preemphasis enable wrong");
    chk_primary_input_only: assert property (wr_at(8'h71) |=>
        primary_input_only_out == ($past(reg_wdata_in) == 8'h00))
        else $error("primary input flag wrong");
    chk_octets_single_lane: assert property (primary_input_only_out &&
        lane_count_out == 5'h00 |-> octets_per_frame_out == 8'h02)
        else $error("octets per frame wrong");
    chk_control_bits_decode: assert property (
        {over_under_bits_enable_out, overrange_bit_enable_out} ==
        control_bits_out)
        else $error("control bit decode wrong");
endmodule

// >>> link_ref_source.sv
// Reference pulse and frame tick source standing in for the link partner.
`timescale 1ns/1ns
module link_ref_source (
    input wire logic clk_in,
    input wire logic fire_in,
    input wire logic tick_in,
    output logic sysref_out,
    output logic frame_tick_out
);
    logic [3:0] pulse = 4'h0;
    initial frame_tick_out = 1'b0;
    // A fired reference stays high four clocks, as a real pulse would.
    always @(posedge clk_in)
    begin
        pulse <= fire_in ? 4'hf : pulse >> 1;
        frame_tick_out <= tick_in;
    end
    assign sysref_out = pulse[0];
endmodule

// >>> serial_link_param_regs_bench.sv
// Self-checking bench for the link parameter register bank.
`timescale 1ns/1ns
module serial_link_param_regs_bench;
    logic clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic fire = 1'b0;
    logic tick = 1'b0;
    logic ref_en = 1'b0;
    logic sysref, frame_tick, hit, scr_en, prim, sub1, drv_en, pre_en;
    logic ovr, ovu, wrap;
    logic [4:0] lanes, phase;
    logic [7:0] rdata, kval, fval, csum;
    logic [1:0] cs;
    int bad_count = 0;
    int total_checks = 0;
    int wraps = 0;
    logic [7:0] e_scr = 8'h01, e_k = 8'h1f, e_cs = 8'h00, e_sub = 8'h01;
    logic [7:0] ra [14] = '{8'h6e, 8'h6f, 8'h70, 8'h71, 8'h72, 8'h73,
        8'h74, 8'h75, 8'h76, 8'h77, 8'h79, 8'h80, 8'h8b, 8'ha8};
    logic [7:0] rv [14] = '{8'h80, 8'h02, 8'h1f, 8'h00, 8'h0d, 8'h2f,
        8'h20, 8'h00, 8'h00, 8'h00, 8'h3f, 8'h00, 8'h00, 8'h04};
    logic [7:0] ta [8] = '{8'h6f, 8'h75, 8'h74, 8'h74, 8'h76, 8'h77,
        8'h80, 8'h79};
    logic [7:0] td [8] = '{8'h55, 8'hff, 8'h1f, 8'h3f, 8'ha5, 8'h5a,
        8'hff, 8'h00};
    logic [7:0] te [8] = '{8'h02, 8'h00, 8'h00, 8'h20, 8'ha5, 8'h5a,
        8'h02, 8'h42};
    logic [7:0] pa [3] = '{8'h14, 8'h04, 8'h15};

    serial_link_param_regs dut (
        .clk_in(clk_in), .reset_in(reset_in), .reg_write_in(wr),
        .reg_read_in(rd), .reg_addr_in(addr), .reg_wdata_in(wdata),
        .reg_rdata_out(rdata), .reg_hit_out(hit), .sysref_pin_in(sysref),
        .sysref_enable_in(ref_en), .frame_tick_in(frame_tick),
        .scramble_enable_out(scr_en), .lane_count_out(lanes),
        .frames_per_multiframe_out(kval), .octets_per_frame_out(fval),
        .primary_input_only_out(prim), .control_bits_out(cs),
        .overrange_bit_enable_out(ovr), .over_under_bits_enable_out(ovu),
        .subclass1_out(sub1), .drivers_enable_out(drv_en),
        .preemphasis_enable_out(pre_en), .multiframe_phase_out(phase),
        .multiframe_wrap_out(wrap), .checksum_out(csum));
    link_ref_source partner (.clk_in(clk_in), .fire_in(fire),
        .tick_in(tick), .sysref_out(sysref), .frame_tick_out(frame_tick));

    initial
    begin
        forever #2 clk_in = ~clk_in;
    end

    // Wrap pulses last one cycle, so they are counted where they settle.
    always @(negedge clk_in)
    begin
        if (wrap === 1'b1)
            wraps++;
    end

    function automatic logic [7:0] sum();
        return e_scr + 8'h02 + e_k + e_cs + 8'h0d + e_sub + 8'h0f;
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_in);
        wr = 1'b1;
        addr = a;
        wdata = d;
        @(negedge clk_in);
        wr = 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] e,
        input logic h);
        @(negedge clk_in);
        rd = 1'b1;
        addr = a;
        @(negedge clk_in);
        rd = 1'b0;
        check(rdata, e);
        check(8'(hit), 8'(h));
    endtask
    task automatic strobe(input bit sr);
        @(negedge clk_in);
        fire = sr;
        tick = !sr;
        @(negedge clk_in);
        fire = 1'b0;
        tick = 1'b0;
        repeat (8) @(negedge clk_in);
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial
    begin
        repeat (16) @(negedge clk_in);
        reset_in = 1'b0;
        foreach (ra[i])
            rd_reg(ra[i], rv[i], 1'b1);
        check(8'(prim), 8'h01);
        check(8'(lanes), 8'h00);
        check(fval, 8'h02);
        rd_reg(8'h78, 8'h00, 1'b0);
        wr_reg(8'h8b, 8'h0a);
        strobe(1'b1);
        check(8'(phase), 8'h00);
        ref_en = 1'b1;
        strobe(1'b1);
        check(8'(phase), 8'h0a);
        strobe(1'b0);
        check(8'(phase), 8'h0b);
        wr_reg(8'h80, 8'h02);
        check(8'(drv_en), 8'h00);
        wr_reg(8'h6e, 8'h60);
        e_scr = 8'h00;
        rd_reg(8'h6e, 8'h00, 1'b1);
        check(8'(scr_en), 8'h00);
        rd_reg(8'h79, sum(), 1'b1);
        wr_reg(8'h6e, 8'h80);
        e_scr = 8'h01;
        check(8'(scr_en), 8'h01);
        wr_reg(8'h70, 8'h20);
        e_k = 8'h20;
        check(kval, 8'h20);
        rd_reg(8'h79, sum(), 1'b1);
        for (int c = 0; c < 4; c++)
        begin
            wr_reg(8'h72, {c[1:0], 6'h3f});
            if (c < 3)
                e_cs = 8'(c);
            rd_reg(8'h72, {e_cs[1:0], 6'h0d}, 1'b1);
            check(8'({ovu, ovr}), e_cs);
            check(8'(cs), e_cs);
            rd_reg(8'h79, sum(), 1'b1);
            check(csum, sum());
        end
        wr_reg(8'h73, 8'h00);
        e_sub = 8'h00;
        rd_reg(8'h73, 8'h0f, 1'b1);
        check(8'(sub1), 8'h00);
        wr_reg(8'h73, 8'hbf);
        e_sub = 8'h01;
        rd_reg(8'h73, 8'h2f, 1'b1);
        check(8'(sub1), 8'h01);
        wr_reg(8'h80, 8'h00);
        foreach (ta[i])
        begin
            wr_reg(ta[i], td[i]);
            rd_reg(ta[i], te[i], 1'b1);
        end
        check(8'(drv_en), 8'h00);
        wr_reg(8'h80, 8'h00);
        check(8'(drv_en), 8'h01);
        foreach (pa[i])
        begin
            wr_reg(8'ha8, pa[i]);
            check(8'(pre_en), 8'(i == 0));
        end
        wr_reg(8'h8b, 8'h00);
        strobe(1'b1);
        strobe(1'b0);
        check(8'(phase), 8'h00);
        check(8'(wraps), 8'h01);
        final_report();
    end

    initial
    begin
        #100000;
        bad_count++;
        final_report();
    end
endmodule

bind serial_link_param_regs link_param_props chk (.*);
